/* File: src/codec_dma_channel.sv */
/*
 * One DMA channel moving bytes between a USB endpoint buffer and the
 * codec port registers, programmed over AXI4-Lite.
 * Assumes the buffer manager and codec port sit on aclk, hold ack low
 * until a request is up and pulse ack for one cycle per byte.
 */
`timescale 1ns/1ps

module codec_dma_channel
    import dma_chan_pkg::*;
(
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic               clk_en,
    input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [ADDR_W-1:0]  s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    input  wire logic               slot_strobe,
    input  wire logic [3:0]         slot_number,
    output logic                    buf_req,
    output byte_req_s               buf_cmd,
    input  wire logic               buf_ack,
    input  wire logic [7:0]         buf_rdata,
    output logic                    codec_req,
    output byte_req_s               codec_cmd,
    input  wire logic               codec_ack,
    input  wire logic [7:0]         codec_rdata,
    output logic [2:0]              endpoint_select,
    output logic                    endpoint_direction,
    output logic                    wrap_buffer_enable,
    output logic                    channel_active
);

    // ************************************************************
    // Register state
    // ************************************************************
    logic                   channel_enable;
    logic [7:0]             slot_select_low;
    logic [7:0]             slot_select_high;
    logic                   overrun;
    logic [13:0]            slot_select;
    logic [1:0]             bytes_per_slot;

    // ************************************************************
    // Engine state
    // ************************************************************
    dma_state_e             state;
    logic [1:0]             byte_count;
    logic [3:0]             current_slot;
    logic                   xfer_in;
    logic                   start;
    logic                   missed;
    logic                   src_ack;
    logic [7:0]             src_data;
    logic                   dst_ack;

    // ************************************************************
    // Bus state
    // ************************************************************
    logic                   aw_held;
    logic                   w_held;
    logic [15:0]            aw_index;
    logic [7:0]             w_byte;
    logic                   w_lane0;
    logic                   do_write;
    logic                   aw_take;
    logic                   w_take;
    logic                   ar_take;
    logic [15:0]            ar_index;
    logic                   wr_hit;

    // ************************************************************
    // Slot decode
    // ************************************************************

    assign slot_select    = {slot_select_high[HIGH_SLOT_MSB:0], slot_select_low};
    assign bytes_per_slot = slot_select_high[HIGH_BPS_MSB:HIGH_BPS_LSB];

    // Slot numbers 14 and 15 do not exist and never start a transfer
    assign start = (state == ST_IDLE) && channel_enable && slot_strobe
                 && (slot_number < 4'(SLOT_COUNT))
                 && slot_select[slot_number];
    assign missed = (state != ST_IDLE) && slot_strobe
                  && (slot_number < 4'(SLOT_COUNT)) && slot_select[slot_number];

    // Source and sink swap with the direction latched at slot start
    assign src_ack  = xfer_in ? codec_ack : buf_ack;
    assign src_data = xfer_in ? codec_rdata : buf_rdata;
    assign dst_ack  = xfer_in ? buf_ack : codec_ack;

    // ************************************************************
    // Transfer engine
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state        <= ST_IDLE;
            byte_count   <= 2'h0;
            current_slot <= 4'h0;
            xfer_in      <= 1'b0;
            buf_req      <= 1'b0;
            buf_cmd      <= '0;
            codec_req    <= 1'b0;
            codec_cmd    <= '0;
        end else if (clk_en) begin
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        state        <= ST_FETCH;
                        byte_count   <= 2'h0;
                        current_slot <= slot_number;
                        xfer_in      <= endpoint_direction;
                        if (endpoint_direction) begin
                            codec_req <= 1'b1;
                            codec_cmd <= '{write: 1'b0, wrap: 1'b0, data: 8'h00};
                        end else begin
                            buf_req <= 1'b1;
                            buf_cmd <= '{write: 1'b0, wrap: wrap_buffer_enable, data: 8'h00};
                        end
                    end
                end
                ST_FETCH: begin
                    if (src_ack) begin
                        state <= ST_STORE;
                        if (xfer_in) begin
                            codec_req <= 1'b0;
                            buf_req   <= 1'b1;
                            buf_cmd   <= '{write: 1'b1, wrap: wrap_buffer_enable, data: src_data};
                        end else begin
                            buf_req   <= 1'b0;
                            codec_req <= 1'b1;
                            codec_cmd <= '{write: 1'b1, wrap: 1'b0, data: src_data};
                        end
                    end
                end
                ST_STORE: begin
                    if (dst_ack) begin
                        buf_req   <= 1'b0;
                        codec_req <= 1'b0;
                        // The slot always completes: a half-moved sample would skew the stream
                        if (byte_count == bytes_per_slot) begin
                            state <= ST_IDLE;
                        end else begin
                            state      <= ST_FETCH;
                            byte_count <= byte_count + 2'h1;
                            if (xfer_in) begin
                                codec_req <= 1'b1;
                                codec_cmd <= '{write: 1'b0, wrap: 1'b0, data: 8'h00};
                            end else begin
                                buf_req <= 1'b1;
                                buf_cmd <= '{write: 1'b0, wrap: wrap_buffer_enable, data: 8'h00};
                            end
                        end
                    end
                end
                default: begin
                    state     <= ST_IDLE;
                    buf_req   <= 1'b0;
                    codec_req <= 1'b0;
                end
            endcase
        end
    end

    // ************************************************************
    // Activity flag
    // ************************************************************
    // Falls with the last acknowledge, so a poll right after sees idle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            channel_active <= 1'b0;
        end else if (clk_en) begin
            channel_active <= start || (state != ST_IDLE && !(state == ST_STORE && dst_ack
                              && byte_count == bytes_per_slot));
        end
    end

    // ************************************************************
    // Write address and data capture, in either order
    // ************************************************************
    assign aw_take  = s_axi_awvalid && s_axi_awready;
    assign w_take   = s_axi_wvalid && s_axi_wready;
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign wr_hit   = (aw_index == IDX_CONTROL) || (aw_index == IDX_SLOT_HIGH)
                    || (aw_index == IDX_SLOT_LOW) || (aw_index == IDX_STATUS);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_index      <= 16'h0000;
            w_byte        <= 8'h00;
            w_lane0       <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else if (clk_en) begin
            if (aw_take) begin
                aw_held       <= 1'b1;
                aw_index      <= s_axi_awaddr[ADDR_W-1:2];
                s_axi_awready <= 1'b0;
            end
            if (w_take) begin
                w_held       <= 1'b1;
                w_byte       <= s_axi_wdata[7:0];
                w_lane0      <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_DECERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                aw_held       <= 1'b0;
                w_held        <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Register writes
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            channel_enable     <= 1'b0;
            wrap_buffer_enable <= 1'b0;
            endpoint_direction <= 1'b0;
            endpoint_select    <= 3'h0;
            slot_select_low    <= RESET_BYTE;
            slot_select_high   <= RESET_BYTE;
        end else if (clk_en && do_write && w_lane0) begin
            if (aw_index == IDX_CONTROL) begin
                channel_enable     <= w_byte[CTL_ENABLE_BIT];
                wrap_buffer_enable <= w_byte[CTL_WRAP_BIT];
                endpoint_direction <= w_byte[CTL_DIR_BIT];
                endpoint_select    <= w_byte[CTL_EP_MSB:0];
            end
            if (aw_index == IDX_SLOT_HIGH) begin
                slot_select_high <= w_byte;
            end
            if (aw_index == IDX_SLOT_LOW) begin
                slot_select_low <= w_byte;
            end
        end
    end

    // ************************************************************
    // Overrun flag
    // ************************************************************
    // Overrun: a selected slot arrived while the previous one was still moving
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            overrun <= 1'b0;
        end else if (clk_en) begin
            if (missed) begin
                overrun <= 1'b1;
            end else if (do_write && w_lane0 && aw_index == IDX_STATUS && w_byte[STAT_OVR_BIT]) begin
                overrun <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Register reads
    // ************************************************************
    assign ar_take  = s_axi_arvalid && s_axi_arready;
    assign ar_index = s_axi_araddr[ADDR_W-1:2];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (clk_en) begin
            if (ar_take) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= RESP_OKAY;
                s_axi_rdata   <= 32'h0000_0000;
                case (ar_index)
                    IDX_CONTROL: begin
                        s_axi_rdata[7:0] <= {channel_enable, wrap_buffer_enable, 2'b00,
                                             endpoint_direction, endpoint_select} & CTL_WRITE_MASK;
                    end
                    IDX_SLOT_HIGH: begin
                        s_axi_rdata[7:0] <= slot_select_high;
                    end
                    IDX_SLOT_LOW: begin
                        s_axi_rdata[7:0] <= slot_select_low;
                    end
                    IDX_STATUS: begin
                        s_axi_rdata[STAT_BUSY_BIT]               <= (state != ST_IDLE);
                        s_axi_rdata[STAT_SLOT_MSB:STAT_SLOT_LSB] <= current_slot;
                        s_axi_rdata[STAT_OVR_BIT]                <= overrun;
                    end
                    default: begin
                        s_axi_rresp <= RESP_DECERR;
                    end
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule

/* File: shared/dma_chan_pkg.sv */
/*
 * Constants, types and register map of the codec DMA channel.
 * Assumes a 32-bit AXI4-Lite register bus, one register per aligned word.
 */
package dma_chan_pkg;

    // ************************************************************
    // Register map (index; byte address is four times the index)
    // ************************************************************
    localparam int              ADDR_W          = 18;
    localparam logic [15:0]     IDX_CONTROL     = 16'hffee;
    localparam logic [15:0]     IDX_SLOT_HIGH   = 16'hffef;
    localparam logic [15:0]     IDX_SLOT_LOW    = 16'hfff0;
    localparam logic [15:0]     IDX_STATUS      = 16'hfff1;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int              CTL_ENABLE_BIT  = 7;
    localparam int              CTL_WRAP_BIT    = 6;
    localparam int              CTL_DIR_BIT     = 3;
    localparam int              CTL_EP_MSB      = 2;
    localparam logic [7:0]      CTL_WRITE_MASK  = 8'hcf;
    localparam int              HIGH_BPS_MSB    = 7;
    localparam int              HIGH_BPS_LSB    = 6;
    localparam int              HIGH_SLOT_MSB   = 5;
    localparam int              STAT_BUSY_BIT   = 0;
    localparam int              STAT_SLOT_LSB   = 1;
    localparam int              STAT_SLOT_MSB   = 4;
    localparam int              STAT_OVR_BIT    = 5;
    localparam logic [7:0]      RESET_BYTE      = 8'h00;
    localparam int              SLOT_COUNT      = 14;

    // ************************************************************
    // Bus answers, states and carriers
    // ************************************************************
    localparam logic [1:0]      RESP_OKAY       = 2'h0;
    localparam logic [1:0]      RESP_DECERR     = 2'h3;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_FETCH = 2'b01,
        ST_STORE = 2'b10
    } dma_state_e;

    typedef struct packed {
        logic       write;
        logic       wrap;
        logic [7:0] data;
    } byte_req_s;

endpackage

/* File: tb/dma_chan_chk.sv */
/* Port assertions for the codec DMA channel.
   Assumes it is bound onto codec_dma_channel; port names match. */
`timescale 1ns/1ps
module dma_chan_chk
    import dma_chan_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        clk_en,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        buf_req,
    input wire byte_req_s   buf_cmd,
    input wire logic        buf_ack,
    input wire logic [7:0]  buf_rdata,
    input wire logic        codec_req,
    input wire byte_req_s   codec_cmd,
    input wire logic        codec_ack,
    input wire logic [7:0]  codec_rdata,
    input wire logic        endpoint_direction,
    input wire logic        wrap_buffer_enable
);
    // ****************************************
    // Relations at the ports
    // ****************************************
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn || !clk_en);

    chk_buf_held:
    assert property (buf_req && !buf_ack |=> buf_req && $stable(buf_cmd)) else $error("buffer request not held");
    chk_codec_held:
    assert property (codec_req && !codec_ack |=> codec_req && $stable(codec_cmd)) else $error("codec request not held");
    chk_out_flow:
    assert property (buf_req && buf_ack && !buf_cmd.write |=> codec_req && codec_cmd.write
        && codec_cmd.data == $past(buf_rdata)) else $error("buffer byte not passed to codec");
    chk_in_flow:
    assert property (codec_req && codec_ack && !codec_cmd.write |=> buf_req && buf_cmd.write
        && buf_cmd.data == $past(codec_rdata)) else $error("codec byte not passed to buffer");
    chk_out_reads:
    assert property ($rose(buf_req) && !buf_cmd.write |-> !endpoint_direction) else $error("buffer read in IN mode");
    chk_in_reads:
    assert property ($rose(codec_req) && !codec_cmd.write |-> endpoint_direction) else $error("codec read in OUT mode");
    chk_wrap_buf:
    assert property ($rose(buf_req) |-> buf_cmd.wrap == wrap_buffer_enable) else $error("wrap flag wrong");
    chk_codec_nowrap:
    assert property (codec_req |-> !codec_cmd.wrap) else $error("wrap flag on codec side");
    chk_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read not answered");
    chk_upper_zero:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
endmodule

bind codec_dma_channel dma_chan_chk chk_u (.*);

/* File: tb/dma_far_model.sv */
/* Far side: endpoint buffer manager and codec port, one responder each.
   Assumes requests are levels held until a one-cycle ack on aclk. */
`timescale 1ns/1ps
module dma_far_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       buf_req,
    input  wire logic       codec_req,
    output logic            buf_ack,
    output logic [7:0]      buf_rdata,
    output logic            codec_ack,
    output logic [7:0]      codec_rdata
);
    // ****************************************
    // Responders with random latency 0..3
    // ****************************************
    int buf_wait;
    int codec_wait;
    // Read data toggles when not answering so a stale byte never passes
    always @(posedge aclk) begin
        buf_rdata <= aresetn ? ~buf_rdata : 8'h00;
        if (!aresetn || buf_ack || !buf_req) begin
            buf_ack <= 1'h0;
            buf_wait <= $urandom_range(3);
        end else if (buf_wait == 0) begin
            buf_ack <= 1'h1;
            buf_rdata <= 8'($urandom);
        end else buf_wait <= buf_wait - 1;
    end
    always @(posedge aclk) begin
        codec_rdata <= aresetn ? ~codec_rdata : 8'h00;
        if (!aresetn || codec_ack || !codec_req) begin
            codec_ack <= 1'h0;
            codec_wait <= $urandom_range(3);
        end else if (codec_wait == 0) begin
            codec_ack <= 1'h1;
            codec_rdata <= 8'($urandom);
        end else codec_wait <= codec_wait - 1;
    end
endmodule

/* File: tb/tb_endpoint_codec_dma_channel.sv */
/* Self-checking bench for the codec DMA channel.
   Assumes the far model answers requests and software writes over AXI4-Lite. */
`timescale 1ns/1ps
module tb_endpoint_codec_dma_channel import dma_chan_pkg::*;;
    // ****************************************
    // Signals, model, tasks and tests
    // ****************************************
    logic              aclk = '0, aresetn = '0, clk_en = 1'h1, slot_strobe = '0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0]       s_axi_wdata = '0, s_axi_rdata;
    logic [3:0]        s_axi_wstrb = '0, slot_number = '0;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic              s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0;
    logic              s_axi_rready = '0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic              s_axi_rvalid, buf_req, buf_ack, codec_req, codec_ack, channel_active;
    logic              endpoint_direction, wrap_buffer_enable;
    logic [7:0]        buf_rdata, codec_rdata;
    logic [2:0]        endpoint_select;
    byte_req_s         buf_cmd, codec_cmd;
    int                n_mismatch = 0, comparisons = 0, n_bytes = 0;
    int                m_sel, m_bps, m_dir, m_wrap, m_en;
    logic [7:0]        src_q[$];

    codec_dma_channel dut_u (.*);
    dma_far_model far_u (.*);
    initial forever #25 aclk = ~aclk;

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t register got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_dat(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t stream got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Every completed destination write must carry the oldest byte read
    task automatic moved(input logic [7:0] d, input int to_buf);
        n_bytes++;
        chk_dat({24'h0, d}, {24'h0, src_q.size() > 0 ? src_q.pop_front() : ~d});
        chk_dat(to_buf, m_dir);
    endtask
    always @(posedge aclk) if (aresetn) begin
        if (buf_req && buf_ack && !buf_cmd.write) src_q.push_back(buf_rdata);
        if (codec_req && codec_ack && !codec_cmd.write) src_q.push_back(codec_rdata);
        if (buf_req && buf_ack) chk_dat(buf_cmd.wrap, m_wrap);
        if (buf_req && buf_ack && buf_cmd.write) moved(buf_cmd.data, 1);
        if (codec_req && codec_ack && codec_cmd.write) moved(codec_cmd.data, 0);
    end

    task automatic axw(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= {idx, 2'h0};
        s_axi_wdata <= {24'($urandom), d};
        s_axi_wstrb <= {3'($urandom), 1'h1};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        chk_reg(s_axi_bresp, er);
    endtask
    task automatic axr(input logic [15:0] idx, input logic [31:0] exp);
        @(posedge aclk);
        s_axi_araddr <= {idx, 2'h0};
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        chk_reg(s_axi_rdata, exp);
        chk_reg(s_axi_rresp, RESP_OKAY);
    endtask

    // Slots and size go in before enable, as software must
    task automatic setup(input int sel, input int bps, input int dir, input int ep, input int en);
        m_sel = sel;
        m_bps = bps;
        m_dir = dir;
        m_wrap = $urandom_range(1);
        m_en = en;
        axw(IDX_CONTROL, 8'h00, RESP_OKAY);
        axw(IDX_SLOT_LOW, sel[7:0], RESP_OKAY);
        axw(IDX_SLOT_HIGH, {bps[1:0], sel[13:8]}, RESP_OKAY);
        axw(IDX_CONTROL, {en[0], m_wrap[0], 2'h3, dir[0], ep[2:0]}, RESP_OKAY);
        axr(IDX_SLOT_HIGH, {24'h0, bps[1:0], sel[13:8]});
        axr(IDX_CONTROL, {24'h0, en[0], m_wrap[0], 2'h0, dir[0], ep[2:0]});
        chk_reg({wrap_buffer_enable, endpoint_direction, endpoint_select}, {m_wrap[0], dir[0], ep[2:0]});
    endtask
    task automatic fire(input int s);
        @(posedge aclk);
        slot_strobe <= 1'h1;
        slot_number <= s[3:0];
        n_bytes = 0;
        @(posedge aclk);
        slot_strobe <= 1'h0;
        slot_number <= 4'($urandom);
    endtask
    task automatic finish(input int nexp);
        int t;
        t = 0;
        repeat (3) @(posedge aclk);
        while (channel_active && t < 400) begin
            @(posedge aclk);
            t++;
        end
        chk_dat(n_bytes, nexp);
        chk_dat(src_q.size(), 0);
    endtask

    initial begin
        void'($urandom(32'hf6d84aaa));
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        axr(IDX_CONTROL, 32'h0);
        axr(IDX_SLOT_HIGH, 32'h0);
        axr(IDX_SLOT_LOW, 32'h0);
        axr(IDX_STATUS, 32'h0);
        axw(16'hfff2, 8'hff, RESP_DECERR);
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            setup($urandom, i % 4, i / 4, 1 + i % 7, 1);
            for (int s = 0; s < 16; s++) begin
                fire(s);
                finish((m_en != 0 && s < 14 && m_sel[s]) ? m_bps + 1 : 0);
            end
        end
        $display("test slots done");
        setup(32'h3fff, 3, 0, 1, 0);
        fire(5);
        finish(0);
        setup(32'h3fff, 3, 1, 7, 1);
        fire(13);
        axw(IDX_CONTROL, {1'h0, m_wrap[0], 6'h0f}, RESP_OKAY);
        finish(4);
        fire(13);
        finish(0);
        $display("test disable done");
        // A second selected strobe while busy is dropped and flagged
        setup(32'h3fff, 3, 0, 2, 1);
        fire(4);
        fire(6);
        axr(IDX_STATUS, 32'(1 << STAT_OVR_BIT | 4 << STAT_SLOT_LSB | 1 << STAT_BUSY_BIT));
        finish(4);
        axw(IDX_STATUS, 8'h20, RESP_OKAY);
        axr(IDX_STATUS, 32'(4 << STAT_SLOT_LSB));
        $display("test overrun done");
        results();
    end
    initial begin
        repeat (40000) @(posedge aclk);
        n_mismatch++;
        results();
    end
endmodule
